/* logic/scd_cmd_decoder.sv */
// scd_cmd_decoder: serial front end taking the command byte and data phases.
// assumes: sclk and din are pins; register contents other than the command byte live outside this block.
// Function
// R1: host opens each transaction with an 8-bit command byte.
// R2: command register is write-only and sets direction, read kind and target.
// R3: after a single read or write the interface goes back to idle.
// R4: power-up and reset put the interface in idle awaiting a command.
// R5: 32 or more serial clocks with data high reset the interface to idle.
// R6: command byte shifts in most significant bit first.
// R7: bit7 write gate, bit6 zero, bits5:4 mode, bit3 zero, bits2:0 select.
// R8: select zero addresses the command register itself.
// R9: while gate bit reads 1, stay on the gate bit position.
// R10: after a gate 0, the next seven bits form the new command.
// R11: host sends zero in reserved bits 6 and 3.
// R12: mode bits 5:4 choose one of four access kinds.
// R13: mode 00 write, 01 read, 10 start continuous read, 11 stop it.
// R14: continuous read repeats the selected register until 30 hex arrives.
// R15: in continuous read data input is sampled on every serial clock.
// R16: data phase lasts the selected register's width, then commands resume.
module scd_cmd_decoder import scd_pkg::*; #(
  parameter int unsigned HIGH_CLOCKS = RESYNC_CLOCKS
) (
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst,
  // serial pins
  input  wire logic               sclk,
  input  wire logic               din,
  output logic                    dout,
  output logic                    dout_en,
  // register side
  input  wire logic               data_wl24,
  input  wire logic [SHIFT_W-1:0] rd_data,
  output logic                    rd_req,
  output logic                    wr_strobe,
  output logic      [SHIFT_W-1:0] wr_data,
  output logic      [2:0]         reg_sel,
  // status
  output logic      [CMD_W-1:0]   command_byte,
  output logic                    cont_read,
  output logic                    if_idle,
  output logic                    part_reset
);

  // ==========================================================================
  // pin sampling and edge detection
  logic [1:0] pins_s;
  logic       sclk_s;
  logic       din_s;
  logic       sclk_prev_q;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       resync_pulse;

  scd_sync2 #(.WIDTH(2)) u_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in ({sclk, din}),
    .sync_out (pins_s)
  );

  assign sclk_s    = pins_s[1];
  assign din_s     = pins_s[0];
  assign sclk_rise = sclk_s & ~sclk_prev_q;
  assign sclk_fall = ~sclk_s & sclk_prev_q;

  // edge history flop
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sclk_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s;
    end
  end

  scd_resync_det #(.HIGH_CLOCKS(HIGH_CLOCKS)) u_resync (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .sclk_rise    (sclk_rise),
    .din_s        (din_s),
    .resync_pulse (resync_pulse)
  );

  // ==========================================================================
  // interface state
  scd_state_type      state_q, state_d;
  logic [CNT_W-1:0]   cnt_q, cnt_d;
  logic [5:0]         cmd_shift_q, cmd_shift_d;
  logic [CMD_W-1:0]   cmd_q, cmd_d;
  logic [2:0]         sel_q, sel_d;
  logic               cont_q, cont_d;
  logic [SHIFT_W-1:0] shift_q, shift_d;
  logic [CMD_W-1:0]   win_q, win_d;
  logic               dout_q, dout_d;
  logic               dout_en_q, dout_en_d;
  logic               rd_req_q, rd_req_d;
  logic               wr_strobe_q, wr_strobe_d;
  logic [SHIFT_W-1:0] wr_data_q, wr_data_d;
  logic               idle_q, idle_d;
  logic               part_reset_q;

  // decode of the byte completing on this edge
  logic [CMD_W-1:0]   new_cmd;
  logic [1:0]         new_mode;
  logic [2:0]         new_sel;
  logic               cmd_done;
  logic [4:0]         width;
  logic [4:0]         load_width;
  logic               phase_last;
  logic               stop_seen;

  assign new_cmd    = {1'b0, cmd_shift_q, din_s};             // [R7]
  assign new_mode   = new_cmd[MODE_HI:MODE_LO];               // [R12]
  assign new_sel    = new_cmd[SEL_MSB:0];
  assign cmd_done   = (state_q == ST_CMD) && sclk_rise && (cnt_q == 5'(CMD_LAST_IDX));
  assign width      = scd_reg_width(sel_q, data_wl24);
  assign load_width = W24 - width;
  assign phase_last = sclk_rise && (cnt_q == width - 5'h01);  // [R16]
  assign stop_seen  = (state_q == ST_READ) && sclk_rise && (cnt_q[2:0] == 3'h7)
                      && ({win_q[6:0], din_s} == STOP_BYTE);  // [R15]

  // next state of the serial interface
  always_comb begin
    state_d     = state_q;
    cnt_d       = cnt_q;
    cmd_shift_d = cmd_shift_q;
    cmd_d       = cmd_q;
    sel_d       = sel_q;
    cont_d      = cont_q;
    shift_d     = shift_q;
    win_d       = win_q;
    dout_d      = dout_q;
    dout_en_d   = dout_en_q;
    rd_req_d    = 1'b0;
    wr_strobe_d = 1'b0;
    wr_data_d   = wr_data_q;
    case (state_q)
      ST_GATE: begin
        dout_en_d = 1'b0;
        if (sclk_rise && !din_s) begin
          state_d = ST_CMD;                                   // [R10]
          cnt_d   = '0;
        end                                                   // gate 1 holds [R9]
      end
      ST_CMD: begin
        if (sclk_rise) begin
          cmd_shift_d = {cmd_shift_q[4:0], din_s};            // msb first [R6]
          cnt_d       = cnt_q + 5'h01;
        end
        if (cmd_done) begin
          cmd_d = new_cmd;                                    // [R2]
          sel_d = new_sel;
          cnt_d = '0;
          case (new_mode)                                     // [R13]
            MODE_WRITE: begin
              // select zero is the command register: next byte is a command
              state_d = (new_sel == SEL_COMMAND) ? ST_GATE : ST_WRITE; // [R8]
            end
            MODE_READ: begin
              state_d  = ST_LOAD;
              rd_req_d = 1'b1;
            end
            MODE_CONT_START: begin
              state_d  = ST_LOAD;
              rd_req_d = 1'b1;
              cont_d   = 1'b1;                                // [R14]
            end
            default: begin
              cont_d  = 1'b0;
              state_d = ST_GATE;
            end
          endcase
        end
      end
      ST_WRITE: begin
        if (sclk_rise) begin
          shift_d = {shift_q[SHIFT_W-2:0], din_s};
          cnt_d   = cnt_q + 5'h01;
        end
        if (phase_last) begin
          wr_strobe_d = 1'b1;
          wr_data_d   = {shift_q[SHIFT_W-2:0], din_s};
          state_d     = ST_GATE;                              // [R3]
        end
      end
      ST_LOAD: begin
        // left-align the register so its msb leaves first
        shift_d   = (sel_q == SEL_COMMAND) ? '0 : (rd_data << load_width);
        win_d     = '0;
        cnt_d     = '0;
        dout_en_d = 1'b1;
        state_d   = ST_READ;
      end
      ST_READ: begin
        if (sclk_fall) begin
          dout_d  = shift_q[SHIFT_W-1];
          shift_d = {shift_q[SHIFT_W-2:0], 1'b0};
        end
        if (sclk_rise) begin
          win_d = {win_q[6:0], din_s};                        // [R15]
          cnt_d = cnt_q + 5'h01;
        end
        if (stop_seen) begin
          cont_d  = 1'b0;
          state_d = ST_GATE;                                  // [R14]
        end else if (phase_last) begin
          if (cont_q) begin
            state_d  = ST_LOAD;                               // [R14]
            rd_req_d = 1'b1;
          end else begin
            state_d = ST_GATE;                                // [R3]
          end
        end
      end
      default: begin
        state_d = ST_GATE;
      end
    endcase
    idle_d = (state_d == ST_GATE);
  end

  // register the interface state; resync acts like reset
  always_ff @(posedge ref_clk) begin
    if (rst || resync_pulse) begin
      state_q     <= ST_GATE;                                 // [R4] [R5]
      cnt_q       <= '0;
      cmd_shift_q <= '0;
      cmd_q       <= '0;
      sel_q       <= SEL_COMMAND;
      cont_q      <= 1'b0;
      shift_q     <= '0;
      win_q       <= '0;
      dout_q      <= 1'b0;
      dout_en_q   <= 1'b0;
      rd_req_q    <= 1'b0;
      wr_strobe_q <= 1'b0;
      wr_data_q   <= '0;
      idle_q      <= 1'b1;
    end else begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      cmd_shift_q <= cmd_shift_d;
      cmd_q       <= cmd_d;
      sel_q       <= sel_d;
      cont_q      <= cont_d;
      shift_q     <= shift_d;
      win_q       <= win_d;
      dout_q      <= dout_d;
      dout_en_q   <= dout_en_d;
      rd_req_q    <= rd_req_d;
      wr_strobe_q <= wr_strobe_d;
      wr_data_q   <= wr_data_d;
      idle_q      <= idle_d;
    end
  end

  // part reset pulse for the rest of the device
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      part_reset_q <= 1'b0;
    end else begin
      part_reset_q <= resync_pulse;                           // [R5]
    end
  end

  // ==========================================================================
  // outputs
  assign dout         = dout_q;
  assign dout_en      = dout_en_q;
  assign rd_req       = rd_req_q;
  assign wr_strobe    = wr_strobe_q;
  assign wr_data      = wr_data_q;
  assign reg_sel      = sel_q;
  assign command_byte = cmd_q;
  assign cont_read    = cont_q;
  assign if_idle      = idle_q;
  assign part_reset   = part_reset_q;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  reset_idle_a: assert property ($past(rst) |-> state_q == ST_GATE && !cont_q) // [R4]
    else $error("interface not idle after reset");
  resync_idle_a: assert property (resync_pulse |=> state_q == ST_GATE && part_reset_q) // [R5]
    else $error("resync did not return to idle");
  gate_hold_a: assert property ((state_q == ST_GATE) && sclk_rise && din_s |=> state_q == ST_GATE) // [R9]
    else $error("gate bit 1 advanced the command");
  gate_open_a: assert property ((state_q == ST_GATE) && sclk_rise && !din_s && !resync_pulse
                                |=> state_q == ST_CMD && cnt_q == 5'h00) // [R10]
    else $error("gate bit 0 did not open the command");
  cmd_msb_a: assert property (cmd_done && !resync_pulse
                              |=> cmd_q[MODE_HI] == $past(cmd_shift_q[4])) // [R6]
    else $error("command bit order wrong");
  mode_read_a: assert property (cmd_done && new_mode == MODE_READ && !resync_pulse
                                |=> rd_req_q && state_q == ST_LOAD ##1 state_q == ST_READ) // [R13]
    else $error("read mode not decoded");
  cont_start_a: assert property (cmd_done && new_mode == MODE_CONT_START && !resync_pulse
                                 |=> cont_q && rd_req_q) // [R14]
    else $error("continuous read not started");
  sel_zero_a: assert property (cmd_done && new_mode == MODE_WRITE && new_sel == SEL_COMMAND
                               && !resync_pulse |=> state_q == ST_GATE && !wr_strobe_q) // [R8]
    else $error("select zero did not address the command register");
  write_len_a: assert property ((state_q == ST_WRITE) && phase_last && !resync_pulse
                                |=> wr_strobe_q && state_q == ST_GATE) // [R3]
    else $error("write phase did not end at register width");
  phase_len_a: assert property ((state_q == ST_WRITE || state_q == ST_READ) |-> cnt_q < width) // [R16]
    else $error("data phase exceeded register width");
  stop_read_a: assert property (stop_seen && !resync_pulse |=> !cont_q && state_q == ST_GATE) // [R15]
    else $error("stop byte missed in continuous read");

  write_cov_c: cover property (wr_strobe_q);
  cont_cov_c: cover property (cont_q && rd_req_q);
  stop_cov_c: cover property (stop_seen);
  resync_cov_c: cover property (resync_pulse);

endmodule : scd_cmd_decoder

/* logic/scd_pkg.sv */
// scd_pkg: constants, types and helpers for the serial command decoder.
// assumes: one 40 MHz core clock; serial pins sampled, never used as clocks.
package scd_pkg;

  // ==========================================================================
  // command byte layout
  localparam int unsigned CMD_W      = 8;
  localparam int unsigned GATE_BIT   = 7;
  localparam int unsigned RSV_HI_BIT = 6;
  localparam int unsigned MODE_HI    = 5;
  localparam int unsigned MODE_LO    = 4;
  localparam int unsigned RSV_LO_BIT = 3;
  localparam int unsigned SEL_MSB    = 2;
  localparam logic [3:0]  CMD_REG_OFFSET = 4'h0;  // command byte register
  localparam logic [2:0]  CMD_LAST_IDX   = 3'h6;  // index of 7th bit after gate

  // ==========================================================================
  // access modes
  localparam logic [1:0] MODE_WRITE      = 2'h0;
  localparam logic [1:0] MODE_READ       = 2'h1;
  localparam logic [1:0] MODE_CONT_START = 2'h2;
  localparam logic [1:0] MODE_CONT_STOP  = 2'h3;
  localparam logic [7:0] STOP_BYTE       = 8'h30;

  // ==========================================================================
  // register selects and widths
  localparam logic [2:0] SEL_COMMAND = 3'h0;
  localparam logic [2:0] SEL_STATUS  = 3'h1;
  localparam logic [2:0] SEL_DATA    = 3'h2;
  localparam logic [2:0] SEL_MODE    = 3'h3;
  localparam logic [2:0] SEL_FILTER  = 3'h4;
  localparam logic [2:0] SEL_DAC     = 3'h5;
  localparam int unsigned SHIFT_W = 24;
  localparam int unsigned CNT_W   = 5;
  localparam logic [4:0] W8  = 5'h08;
  localparam logic [4:0] W16 = 5'h10;
  localparam logic [4:0] W24 = 5'h18;

  // ==========================================================================
  // resynchronisation
  localparam int unsigned RESYNC_CLOCKS = 32;

  // ==========================================================================
  // interface states
  typedef enum logic [2:0] {
    ST_GATE,
    ST_CMD,
    ST_WRITE,
    ST_LOAD,
    ST_READ
  } scd_state_type;

  // data phase length in serial clocks for a register select
  function automatic logic [4:0] scd_reg_width(input logic [2:0] sel,
                                               input logic       wl24);
    case (sel)
      SEL_COMMAND: scd_reg_width = W8;
      SEL_STATUS:  scd_reg_width = W8;
      SEL_DATA:    scd_reg_width = wl24 ? W24 : W16;
      SEL_MODE:    scd_reg_width = W16;
      SEL_FILTER:  scd_reg_width = W24;
      SEL_DAC:     scd_reg_width = W8;
      default:     scd_reg_width = W24;
    endcase
  endfunction : scd_reg_width

endpackage : scd_pkg

/* logic/scd_resync_det.sv */
// scd_resync_det: counts serial clocks with data held high, pulses at limit.
// assumes: rise is a one-cycle pulse per serial clock rising edge.
module scd_resync_det import scd_pkg::*; #(
  parameter int unsigned HIGH_CLOCKS = RESYNC_CLOCKS
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // sampled link
  input  wire logic sclk_rise,
  input  wire logic din_s,
  // detection pulse
  output logic      resync_pulse
);

  localparam logic [5:0] LAST = 6'(HIGH_CLOCKS - 1);

  logic [5:0] run_q;
  logic [5:0] run_d;
  logic       pulse_q;
  logic       pulse_d;

  // next count: any low bit restarts the run
  always_comb begin
    run_d   = run_q;
    pulse_d = 1'b0;
    if (sclk_rise) begin
      if (!din_s) begin
        run_d = 6'h00;
      end else if (run_q == LAST) begin
        run_d   = 6'h00;
        pulse_d = 1'b1; // [R5]
      end else begin
        run_d = run_q + 6'h01;
      end
    end
  end

  // register count and pulse
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      run_q   <= 6'h00;
      pulse_q <= 1'b0;
    end else begin
      run_q   <= run_d;
      pulse_q <= pulse_d;
    end
  end

  assign resync_pulse = pulse_q;

endmodule : scd_resync_det

/* logic/scd_sync2.sv */
// scd_sync2: two flip-flop synchroniser, one stage pair per bit.
// assumes: inputs are asynchronous pins; only stage two is read outside.
module scd_sync2 import scd_pkg::*; #(
  parameter int unsigned WIDTH = 2
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // pins and synchronised copies
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ==========================================================================
  // per-bit flop pair
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic meta_q;
      logic meta_d;
      logic stab_q;
      logic stab_d;
      // next values: stage two reads stage one only
      always_comb begin
        meta_d = async_in[gi];
        stab_d = meta_q;
      end
      // register both stages, idle level high
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          meta_q <= 1'b1;
          stab_q <= 1'b1;
        end else begin
          meta_q <= meta_d;
          stab_q <= stab_d;
        end
      end
      assign sync_out[gi] = stab_q;
    end
  endgenerate

endmodule : scd_sync2

/* tb/scd_host_model.sv */
// scd_host_model: host serial port that clocks bytes into the decoder.
// assumes: the bench calls xfer; sclk stands high between frames.
module scd_host_model (
  // core clock used for pacing
  input  wire logic ref_clk,
  // serial pins
  output logic      sclk,
  output logic      din,
  input  wire logic dout,
  input  wire logic dout_en
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // idle levels at time zero
  initial begin
    sclk = 1'b1;
    din  = 1'b1;
  end

  // ==========================================================================
  // one frame: msb first, 8 core cycles per serial clock (200 ns)
  // callers put the command byte first and zero in reserved bits
  // long runs of ones and the stop byte are sent through here too
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    int i;
    rx = '0;
    for (i = n - 1; i >= 0; i--) begin
      @(posedge ref_clk);
      sclk <= 1'b0;
      din  <= tx[i];
      repeat (4) @(posedge ref_clk);
      // a released output shows the inverse so a late enable is caught
      rx = {rx[30:0], dout_en ? dout : ~dout};  // taken at the rising edge
      sclk <= 1'b1;
      repeat (3) @(posedge ref_clk);
    end
  endtask : xfer
endmodule : scd_host_model

/* tb/tb.sv */
// tb: self-checking bench for the serial command decoder.
// assumes: 40 MHz ref_clk, host model on the pins, register file modelled here.
module tb import scd_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;

  logic               ref_clk;
  logic               rst;
  logic               sclk;
  logic               din;
  logic               dout;
  logic               dout_en;
  logic               data_wl24;
  logic [SHIFT_W-1:0] rd_data;
  logic               rd_req;
  logic               wr_strobe;
  logic [SHIFT_W-1:0] wr_data;
  logic [2:0]         reg_sel;
  logic [CMD_W-1:0]   command_byte;
  logic               cont_read;
  logic               if_idle;
  logic               part_reset;
  logic [23:0]        last_wr;
  int                 wr_cnt;
  int                 rd_cnt;
  int                 prst_cnt;
  int                 cycles;
  int                 error_cnt;
  int                 checks_done;

  // ==========================================================================
  // instances
  scd_cmd_decoder i_scd_cmd_decoder (
    .ref_clk(ref_clk), .rst(rst), .sclk(sclk), .din(din), .dout(dout),
    .dout_en(dout_en), .data_wl24(data_wl24), .rd_data(rd_data), .rd_req(rd_req),
    .wr_strobe(wr_strobe), .wr_data(wr_data), .reg_sel(reg_sel),
    .command_byte(command_byte), .cont_read(cont_read), .if_idle(if_idle),
    .part_reset(part_reset)
  );
  scd_host_model i_scd_host_model (
    .ref_clk(ref_clk), .sclk(sclk), .din(din), .dout(dout), .dout_en(dout_en)
  );

  // ==========================================================================
  // clock, register file model and pulse monitors
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  function automatic logic [23:0] pat(input logic [2:0] sel);
    pat = 24'hc35a96 ^ {3{5'h00, sel}};
  endfunction : pat

  function automatic int wid(input logic [2:0] sel, input logic wl);
    case (sel)
      3'h2:    wid = wl ? 24 : 16;
      3'h3:    wid = 16;
      3'h4:    wid = 24;
      default: wid = 8;
    endcase
  endfunction : wid

  // register file read mux: combinational from reg_sel, valid in the same cycle as rd_req
  assign rd_data = pat(reg_sel);

  always @(posedge ref_clk) begin
    if (wr_strobe === 1'b1) begin
      wr_cnt++;
      last_wr <= wr_data;
    end
    if (rd_req === 1'b1) rd_cnt++;
    if (part_reset === 1'b1) prst_cnt++;
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  // ==========================================================================
  // helpers
  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic settle();
    repeat (8) @(posedge ref_clk);
  endtask : settle

  task automatic send(input logic [31:0] v, input int n, output logic [31:0] rx);
    i_scd_host_model.xfer(v, n, rx);
  endtask : send

  // write: optional ones before the gate, command, then the data phase
  task automatic do_write(input logic [2:0] sel, input logic [23:0] v, input int w,
                          input int ones);
    int          n0;
    logic [31:0] rx;
    logic [23:0] mask;
    n0   = wr_cnt;
    mask = (24'h1 << w) - 24'h1;
    send(({32{1'b1}} << 8) | {24'h0, 5'h00, sel}, 8 + ones, rx);
    settle();
    check(command_byte === {5'h00, sel}, "command byte");
    check(reg_sel === sel, "register select");
    check(if_idle === 1'b0, "write phase not entered");
    send({8'h00, v}, w, rx);
    settle();
    check(wr_cnt === n0 + 1, "write strobe count");
    check((last_wr & mask) === v, "write data");
    check(if_idle === 1'b1, "not idle after write");
  endtask : do_write

  // single read of one select
  task automatic do_read(input logic [2:0] sel, input logic wl);
    int          n0;
    int          w;
    logic [31:0] rx;
    logic [23:0] exp;
    data_wl24 <= wl;
    n0  = rd_cnt;
    w   = wid(sel, wl);
    exp = (sel == SEL_COMMAND) ? 24'h0 : pat(sel) & ((24'h1 << w) - 24'h1);
    send(32'h10 | {29'h0, sel}, 8, rx);
    settle();
    check(dout_en === 1'b1, "read phase not entered");
    send(32'h0, w, rx);
    settle();
    check(rx === {8'h00, exp}, "read data");
    check(rd_cnt === n0 + 1, "read request count");
    check(if_idle === 1'b1 && dout_en === 1'b0, "not idle after read");
  endtask : do_read

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  // ==========================================================================
  // main sequence
  initial begin
    logic [31:0] rx;
    int          s;
    int          n0;
    rst       = 1'b1;
    data_wl24 = 1'b0;
    wr_cnt    = 0;
    rd_cnt    = 0;
    prst_cnt  = 0;
    cycles    = 0;
    error_cnt = 0;
    checks_done = 0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check(if_idle === 1'b1 && cont_read === 1'b0, "reset state");
    check(dout_en === 1'b0 && reg_sel === 3'h0, "reset outputs");
    $display("test reset done");

    do_write(3'h5, 24'h0000a5, 8, 5);
    do_write(3'h3, 24'h00beef, 16, 0);
    do_write(3'h4, 24'h5a3c96, 24, 0);
    $display("test writes done");

    for (s = 0; s < 6; s++) do_read(s[2:0], 1'b0);
    do_read(3'h2, 1'b1);
    $display("test reads done");

    // continuous read of the data register, then the stop byte
    data_wl24 <= 1'b0;
    send(32'h22, 8, rx);
    settle();
    check(cont_read === 1'b1, "continuous mode not set");
    send(32'h0, 16, rx);
    settle();
    check(rx === {8'h00, pat(3'h2) & 24'h00ffff}, "continuous data");
    check(cont_read === 1'b1 && if_idle === 1'b0, "continuous reload");
    send(32'h30, 8, rx);
    settle();
    check(cont_read === 1'b0 && if_idle === 1'b1, "stop byte ignored");
    n0 = rd_cnt + wr_cnt;
    send(32'h30, 8, rx);
    settle();
    check(if_idle === 1'b1 && rd_cnt + wr_cnt === n0, "stop command from idle");
    send(32'h00, 8, rx);
    settle();
    check(if_idle === 1'b1 && command_byte === 8'h00 && rd_cnt + wr_cnt === n0,
          "select zero write");
    $display("test continuous done");

    // 31 ones inside a continuous read do nothing, the 32nd resets
    data_wl24 <= 1'b1;
    send(32'h22, 8, rx);
    send(32'h7fffffff, 31, rx);
    settle();
    check(prst_cnt === 0 && cont_read === 1'b1, "early resync");
    send(32'h1, 1, rx);
    settle();
    check(prst_cnt === 1, "resync pulse");
    check(if_idle === 1'b1 && cont_read === 1'b0, "resync state");
    $display("test resync done");
    stop_test();
  end
endmodule : tb
